// File: core/eirqts_top.v
`timescale 1ns/1ps
`include "eirqts_defines.vh"

//Behaviour
//- Each counter is 16 bits wide and adds one on every clock while running.
//- A valid edge on the line clears its counter to zero, after which it counts on.
//- While the line is disabled its counter holds its value.
//- The counter wraps from its top value to zero with no indication.
//- Software can only read the counters; only a valid edge or reset clears them.
//- The second line's counter reads at word index 7079h and is zero after reset.
//- The non-maskable line's counter reads at word index 707Fh and works the same way.
//- The first line's counter reads at word index 7078h.
//- Polarity 00 or 10 picks falling edges, 01 rising edges, 11 both.
//- Bit 0 of each line's control register enables the line and its counter.
module eirqts_top (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	irq1_pin,
	irq2_pin,
	nmi_pin,
	irq
);
	input wire pclk;
	input wire presetn;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [31:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output wire pready;
	output wire pslverr;
	input wire irq1_pin;
	input wire irq2_pin;
	input wire nmi_pin;
	output wire irq;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [3:0] irq1_ctrl_reg;
	reg [3:0] irq1_ctrl_next;
	reg [3:0] irq2_ctrl_reg;
	reg [3:0] irq2_ctrl_next;
	reg [3:0] nmi_ctrl_reg;
	reg [3:0] nmi_ctrl_next;
	reg [`EIRQTS_EV_W-1:0] status_reg;
	reg [`EIRQTS_EV_W-1:0] status_next;
	reg [`EIRQTS_EV_W-1:0] mask_reg;
	reg [`EIRQTS_EV_W-1:0] mask_next;
	reg err_reg;
	reg [31:0] rdata_next;
	reg err_next;

	// ----------------------------------------
	// Bus decode and per-line nets
	// ----------------------------------------
	wire [29:0] widx;
	wire lane_ok;
	wire setup;
	wire access;
	wire wr_access;
	wire wr_ok;
	wire hit_irq1_ctrl;
	wire hit_irq2_ctrl;
	wire hit_nmi_ctrl;
	wire hit_irq1_count;
	wire hit_irq2_count;
	wire hit_nmi_count;
	wire hit_status;
	wire hit_mask;
	wire hit_any;
	wire wr_irq1_ctrl;
	wire wr_irq2_ctrl;
	wire wr_nmi_ctrl;
	wire wr_status;
	wire wr_mask;
	wire irq1_enable;
	wire irq2_enable;
	wire nmi_enable;
	wire [1:0] irq1_polarity;
	wire [1:0] irq2_polarity;
	wire [1:0] nmi_polarity;
	wire [31:0] irq1_ctrl_word;
	wire [31:0] irq2_ctrl_word;
	wire [31:0] nmi_ctrl_word;
	wire [31:0] irq1_count_word;
	wire [31:0] irq2_count_word;
	wire [31:0] nmi_count_word;
	wire [31:0] status_word;
	wire [31:0] mask_word;
	wire [`EIRQTS_EV_W-1:0] events;
	wire [`EIRQTS_EV_W-1:0] pending;
	wire [`EIRQTS_CNT_W-1:0] irq1_count;
	wire [`EIRQTS_CNT_W-1:0] irq2_count;
	wire [`EIRQTS_CNT_W-1:0] nmi_count;

	// ----------------------------------------
	// Bus phases
	// ----------------------------------------
	assign widx = paddr[31:2];
	assign lane_ok = (paddr[1:0] == `EIRQTS_LANE_OK);
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_access = access & pwrite;
	assign wr_ok = wr_access & ~err_reg;
	assign pready = 1'h1;
	assign pslverr = access & err_reg;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign hit_irq1_ctrl = (widx == `EIRQTS_IDX_IRQ1_CTRL);
	assign hit_irq2_ctrl = (widx == `EIRQTS_IDX_IRQ2_CTRL);
	assign hit_nmi_ctrl = (widx == `EIRQTS_IDX_NMI_CTRL);
	assign hit_irq1_count = (widx == `EIRQTS_IDX_IRQ1_COUNT);
	assign hit_irq2_count = (widx == `EIRQTS_IDX_IRQ2_COUNT);
	assign hit_nmi_count = (widx == `EIRQTS_IDX_NMI_COUNT);
	assign hit_status = (widx == `EIRQTS_IDX_STATUS);
	assign hit_mask = (widx == `EIRQTS_IDX_MASK);
	assign hit_any = hit_irq1_ctrl | hit_irq2_ctrl | hit_nmi_ctrl | hit_irq1_count
		| hit_irq2_count | hit_nmi_count | hit_status | hit_mask;

	// Counter words get no write strobe, so writes to them are dropped
	assign wr_irq1_ctrl = wr_ok & hit_irq1_ctrl;
	assign wr_irq2_ctrl = wr_ok & hit_irq2_ctrl;
	assign wr_nmi_ctrl = wr_ok & hit_nmi_ctrl;
	assign wr_status = wr_ok & hit_status;
	assign wr_mask = wr_ok & hit_mask;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	assign irq1_enable = irq1_ctrl_reg[`EIRQTS_CTRL_EN];
	assign irq2_enable = irq2_ctrl_reg[`EIRQTS_CTRL_EN];
	assign nmi_enable = nmi_ctrl_reg[`EIRQTS_CTRL_EN];
	assign irq1_polarity = irq1_ctrl_reg[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];
	assign irq2_polarity = irq2_ctrl_reg[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];
	assign nmi_polarity = nmi_ctrl_reg[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];

	// ----------------------------------------
	// Register words as read back
	// ----------------------------------------
	assign irq1_ctrl_word = {28'h0000000, irq1_ctrl_reg};
	assign irq2_ctrl_word = {28'h0000000, irq2_ctrl_reg};
	assign nmi_ctrl_word = {28'h0000000, nmi_ctrl_reg};
	assign irq1_count_word = {16'h0000, irq1_count};
	assign irq2_count_word = {16'h0000, irq2_count};
	assign nmi_count_word = {16'h0000, nmi_count};
	assign status_word = {29'h00000000, status_reg};
	assign mask_word = {29'h00000000, mask_reg};

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	assign pending = status_reg & mask_reg;
	assign irq = |pending;

	// ----------------------------------------
	// Per-line edge detect and counters
	// ----------------------------------------
	eirqts_edge_detect u_edge1 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(irq1_pin),
		.enable(irq1_enable),
		.polarity(irq1_polarity),
		.valid_edge(events[`EIRQTS_EV_IRQ1])
	);

	eirqts_edge_detect u_edge2 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(irq2_pin),
		.enable(irq2_enable),
		.polarity(irq2_polarity),
		.valid_edge(events[`EIRQTS_EV_IRQ2])
	);

	eirqts_edge_detect u_edge_nmi (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(nmi_pin),
		.enable(nmi_enable),
		.polarity(nmi_polarity),
		.valid_edge(events[`EIRQTS_EV_NMI])
	);

	eirqts_ts_counter u_cnt1 (
		.pclk(pclk),
		.presetn(presetn),
		.enable(irq1_enable),
		.clear(events[`EIRQTS_EV_IRQ1]),
		.count(irq1_count)
	);

	eirqts_ts_counter u_cnt2 (
		.pclk(pclk),
		.presetn(presetn),
		.enable(irq2_enable),
		.clear(events[`EIRQTS_EV_IRQ2]),
		.count(irq2_count)
	);

	eirqts_ts_counter u_cnt_nmi (
		.pclk(pclk),
		.presetn(presetn),
		.enable(nmi_enable),
		.clear(events[`EIRQTS_EV_NMI]),
		.count(nmi_count)
	);

	// ----------------------------------------
	// Read decode, sampled in the setup phase
	// ----------------------------------------
	always @* begin
		rdata_next = `EIRQTS_ZERO32;
		err_next = ~(lane_ok & hit_any);
		if (!err_next && !pwrite) begin
			case (widx)
				`EIRQTS_IDX_IRQ1_CTRL: rdata_next = irq1_ctrl_word;
				`EIRQTS_IDX_IRQ2_CTRL: rdata_next = irq2_ctrl_word;
				`EIRQTS_IDX_NMI_CTRL: rdata_next = nmi_ctrl_word;
				`EIRQTS_IDX_IRQ1_COUNT: rdata_next = irq1_count_word;
				`EIRQTS_IDX_IRQ2_COUNT: rdata_next = irq2_count_word;
				`EIRQTS_IDX_NMI_COUNT: rdata_next = nmi_count_word;
				`EIRQTS_IDX_STATUS: rdata_next = status_word;
				`EIRQTS_IDX_MASK: rdata_next = mask_word;
				default: rdata_next = `EIRQTS_ZERO32;
			endcase
		end
	end

	// Read data and error flag stand from one setup to the next
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `EIRQTS_ZERO32;
			err_reg <= 1'h0;
		end else if (setup) begin
			prdata <= rdata_next;
			err_reg <= err_next;
		end
	end

	// ----------------------------------------
	// Control registers; unused bits read zero
	// ----------------------------------------
	always @* begin
		irq1_ctrl_next = irq1_ctrl_reg;
		if (wr_irq1_ctrl) begin
			irq1_ctrl_next = `EIRQTS_CTRL_RST;
			irq1_ctrl_next[`EIRQTS_CTRL_EN] = pwdata[`EIRQTS_CTRL_EN];
			irq1_ctrl_next[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO] =
				pwdata[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq1_ctrl_reg <= `EIRQTS_CTRL_RST;
		end else begin
			irq1_ctrl_reg <= irq1_ctrl_next;
		end
	end

	always @* begin
		irq2_ctrl_next = irq2_ctrl_reg;
		if (wr_irq2_ctrl) begin
			irq2_ctrl_next = `EIRQTS_CTRL_RST;
			irq2_ctrl_next[`EIRQTS_CTRL_EN] = pwdata[`EIRQTS_CTRL_EN];
			irq2_ctrl_next[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO] =
				pwdata[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq2_ctrl_reg <= `EIRQTS_CTRL_RST;
		end else begin
			irq2_ctrl_reg <= irq2_ctrl_next;
		end
	end

	// The select bit is kept for software only; it does not gate the counter
	always @* begin
		nmi_ctrl_next = nmi_ctrl_reg;
		if (wr_nmi_ctrl) begin
			nmi_ctrl_next = `EIRQTS_CTRL_RST;
			nmi_ctrl_next[`EIRQTS_CTRL_EN] = pwdata[`EIRQTS_CTRL_EN];
			nmi_ctrl_next[`EIRQTS_CTRL_SEL] = pwdata[`EIRQTS_CTRL_SEL];
			nmi_ctrl_next[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO] =
				pwdata[`EIRQTS_CTRL_POL_HI:`EIRQTS_CTRL_POL_LO];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_ctrl_reg <= `EIRQTS_CTRL_RST;
		end else begin
			nmi_ctrl_reg <= nmi_ctrl_next;
		end
	end

	// ----------------------------------------
	// Interrupt mask and sticky status
	// ----------------------------------------
	always @* begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = pwdata[`EIRQTS_EV_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= `EIRQTS_EV_RST;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// A new edge in the clearing cycle keeps its bit set
	always @* begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~pwdata[`EIRQTS_EV_W-1:0];
		end
		status_next = status_next | events;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= `EIRQTS_EV_RST;
		end else begin
			status_reg <= status_next;
		end
	end
endmodule // eirqts_top

// File: core/eirqts_defines.vh
`ifndef EIRQTS_DEFINES_VH
`define EIRQTS_DEFINES_VH

// Word indices; the byte address is four times the index
`define EIRQTS_IDX_IRQ1_CTRL 30'h00007070
`define EIRQTS_IDX_IRQ2_CTRL 30'h00007071
`define EIRQTS_IDX_NMI_CTRL 30'h00007077
`define EIRQTS_IDX_IRQ1_COUNT 30'h00007078
`define EIRQTS_IDX_IRQ2_COUNT 30'h00007079
`define EIRQTS_IDX_NMI_COUNT 30'h0000707f
`define EIRQTS_IDX_STATUS 30'h00007080
`define EIRQTS_IDX_MASK 30'h00007081

`define EIRQTS_CNT_W 16
`define EIRQTS_CNT_RST 16'h0000
`define EIRQTS_CNT_ONE 16'h0001

// Control register fields
`define EIRQTS_CTRL_EN 0
`define EIRQTS_CTRL_SEL 1
`define EIRQTS_CTRL_POL_HI 3
`define EIRQTS_CTRL_POL_LO 2
`define EIRQTS_CTRL_RST 4'h0

// Polarity codes
`define EIRQTS_POL_FALL0 2'h0
`define EIRQTS_POL_RISE 2'h1
`define EIRQTS_POL_FALL1 2'h2
`define EIRQTS_POL_BOTH 2'h3

// Status and mask bits
`define EIRQTS_EV_IRQ1 0
`define EIRQTS_EV_IRQ2 1
`define EIRQTS_EV_NMI 2
`define EIRQTS_EV_W 3
`define EIRQTS_EV_RST 3'h0

`define EIRQTS_SYNC_RST 1'h0
`define EIRQTS_ZERO32 32'h00000000
`define EIRQTS_LANE_OK 2'h0

`endif

// File: core/eirqts_edge_detect.v
`timescale 1ns/1ps
`include "eirqts_defines.vh"

module eirqts_edge_detect (
	pclk,
	presetn,
	pin_in,
	enable,
	polarity,
	valid_edge
);
	input wire pclk;
	input wire presetn;
	input wire pin_in;
	input wire enable;
	input wire [1:0] polarity;
	output reg valid_edge;

	reg sync1_reg;
	reg sync2_reg;
	reg prev_reg;
	reg rise;
	reg fall;

	// ----------------------------------------
	// Synchroniser and edge history
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= `EIRQTS_SYNC_RST;
			sync2_reg <= `EIRQTS_SYNC_RST;
			prev_reg <= `EIRQTS_SYNC_RST;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ----------------------------------------
	// Edge select
	// ----------------------------------------
	always @* begin
		rise = sync2_reg & ~prev_reg;
		fall = ~sync2_reg & prev_reg;
		case (polarity)
			`EIRQTS_POL_FALL0: valid_edge = enable & fall;
			`EIRQTS_POL_RISE: valid_edge = enable & rise;
			`EIRQTS_POL_FALL1: valid_edge = enable & fall;
			`EIRQTS_POL_BOTH: valid_edge = enable & (rise | fall);
			default: valid_edge = 1'h0;
		endcase
	end
endmodule // eirqts_edge_detect

// File: core/eirqts_ts_counter.v
`timescale 1ns/1ps
`include "eirqts_defines.vh"

module eirqts_ts_counter (
	pclk,
	presetn,
	enable,
	clear,
	count
);
	input wire pclk;
	input wire presetn;
	input wire enable;
	input wire clear;
	output reg [`EIRQTS_CNT_W-1:0] count;

	// Wraps silently past the top value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `EIRQTS_CNT_RST;
		end else if (clear) begin
			count <= `EIRQTS_CNT_RST;
		end else if (enable) begin
			count <= count + `EIRQTS_CNT_ONE;
		end
	end
endmodule // eirqts_ts_counter

// File: dv/eirqts_pin_drv.sv
`timescale 1ns/1ps
// Outside circuitry on the three interrupt pins; levels change only after a clock edge
module eirqts_pin_drv (
	input wire pclk,
	input wire [2:0] lvl,
	output logic [2:0] pins
);
	initial pins = 3'h7;
	always @(posedge pclk) begin
		pins <= lvl;
	end
endmodule // eirqts_pin_drv

// File: dv/eirqts_props.sv
`timescale 1ns/1ps
`include "eirqts_defines.vh"
module eirqts_props (
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr, irq,
	input wire [31:0] paddr, pwdata, prdata
);
	wire acc = psel && penable;
	wire is_cnt = paddr[31:2] == `EIRQTS_IDX_IRQ1_COUNT || paddr[31:2] == `EIRQTS_IDX_IRQ2_COUNT
		|| paddr[31:2] == `EIRQTS_IDX_NMI_COUNT;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
	chk_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned accepted");
	chk_cnt_mapped: assert property (acc && is_cnt && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("counter unmapped");
	chk_cnt_width: assert property (acc && !pwrite && is_cnt |-> prdata[31:16] == 16'h0)
		else $error("counter wider than 16 bits");
	chk_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	chk_rd_stands: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved");
	chk_wr_zero: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
		else $error("write data nonzero");
	chk_irq_reset: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
endmodule // eirqts_props
bind eirqts_top eirqts_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .irq, .paddr, .pwdata, .prdata);

// File: dv/eirqts_tb_top.sv
`timescale 1ns/1ps
`include "eirqts_defines.vh"
module eirqts_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [31:0] paddr = 0, pwdata = 0, rd;
	logic [2:0] lvl = 3'h7;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [2:0] pins;
	int error_cnt = 0, cmp_count = 0;
	logic [29:0] cidx [3] = '{`EIRQTS_IDX_IRQ1_COUNT, `EIRQTS_IDX_IRQ2_COUNT, `EIRQTS_IDX_NMI_COUNT};
	logic [29:0] ctl [3] = '{`EIRQTS_IDX_IRQ1_CTRL, `EIRQTS_IDX_IRQ2_CTRL, `EIRQTS_IDX_NMI_CTRL};
	always #20 pclk = ~pclk;
	eirqts_pin_drv u_pins (.pclk, .lvl, .pins);
	eirqts_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq1_pin(pins[0]), .irq2_pin(pins[1]), .nmi_pin(pins[2]), .irq);
	task automatic chk(input logic [31:0] got, exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] d,
		input logic [1:0] lo = 2'h0);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, lo};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task t_reset;
		for (int i = 0; i < 3; i++) begin
			apb(0, cidx[i], 0);
			chk(rd, 0, "reset count");
		end
		$display("t_reset done");
	endtask
	task t_run;
		logic [31:0] a;
		for (int i = 0; i < 3; i++) begin
			apb(1, ctl[i], 1);
			apb(0, cidx[i], 0);
			a = rd;
			apb(1, cidx[i], 32'hffff);
			chk(err, 0, "ro write");
			apb(0, cidx[i], 0);
			chk(rd, a + 6, "count step");
			apb(1, ctl[i], 0);
			apb(0, cidx[i], 0);
			a = rd;
			lvl[i] <= 0;
			repeat (8) @(posedge pclk);
			apb(0, cidx[i], 0);
			chk(rd, a, "hold");
			lvl[i] <= 1;
			repeat (8) @(posedge pclk);
		end
		apb(0, `EIRQTS_IDX_STATUS, 0);
		chk(rd, 0, "disabled edge");
		$display("t_run done");
	endtask
	task t_edge;
		logic v;
		apb(1, `EIRQTS_IDX_MASK, 7);
		for (int i = 0; i < 3; i++)
			for (int p = 0; p < 4; p++) begin
				apb(1, ctl[i], p * 4 + 1);
				for (int d = 0; d < 2; d++) begin
					v = d ? p[0] : (p != 1);
					apb(1, `EIRQTS_IDX_STATUS, 7);
					repeat (40) @(posedge pclk);
					lvl[i] <= d[0];
					repeat (8) @(posedge pclk);
					chk(irq, v, "irq level");
					apb(0, `EIRQTS_IDX_STATUS, 0);
					chk(rd, 32'(v) << i, "status");
					apb(0, cidx[i], 0);
					chk(rd < 16, v, "edge clear");
				end
			end
		$display("t_edge done");
	endtask
	task t_irq;
		apb(1, `EIRQTS_IDX_MASK, 3);
		chk(irq, 0, "masked");
		apb(1, `EIRQTS_IDX_MASK, 4);
		chk(irq, 1, "unmasked");
		apb(1, `EIRQTS_IDX_STATUS, 4);
		chk(irq, 0, "cleared");
		$display("t_irq done");
	endtask
	task t_wrap;
		logic [31:0] a;
		apb(0, cidx[0], 0);
		a = rd;
		repeat (65533) @(posedge pclk);
		apb(0, cidx[0], 0);
		chk(rd, a, "wrap");
		apb(0, `EIRQTS_IDX_STATUS, 0);
		chk(rd, 0, "wrap silent");
		$display("t_wrap done");
	endtask
	task t_err;
		apb(0, 30'h00007072, 0);
		chk(err, 1, "unmapped error");
		chk(rd, 0, "unmapped data");
		apb(0, cidx[0], 0, 2'h1);
		chk(err, 1, "misaligned");
		apb(1, ctl[0], 32'hffff);
		apb(0, ctl[0], 0);
		chk(rd, 32'hd, "ctrl bits");
		$display("t_err done");
	endtask
	initial begin
		#3600000;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_run;
		t_edge;
		t_irq;
		t_wrap;
		t_err;
		print_verdict;
	end
endmodule // eirqts_tb_top
